// ---- rtl/port_b_c_alt_function_override.sv ----
// Alternate-function override for port B and the test pins of port C
`timescale 1ns/1ns
module port_b_c_alt_function_override (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Port B registers
   input wire logic [7:0] portbDir,
   input wire logic [7:0] portbOut,
   input wire logic global_pullup_disable,
   // Serial peripheral
   input wire logic serial_periph_enable,
   input wire logic serial_master_select,
   input wire logic spiClkOut,
   input wire logic spiMasterOut,
   input wire logic spiSlaveOut,
   output logic spiClkIn,
   output logic spiMasterIn,
   output logic spiSlaveIn,
   output logic spiSlaveActive,
   // Second serial port
   input wire logic serial1_tx_enable,
   input wire logic serial1_rx_enable,
   input wire logic serial1TxData,
   output logic serial1RxData,
   // Timers and clock output
   input wire logic timer0_compare_out,
   input wire logic timer2_compare_out,
   input wire logic timer3_compare_b_out,
   output logic timer0_ext_count_in,
   output logic timer1_ext_count_in,
   input wire logic clock_out_fuse,
   input wire logic clkIoDiv,
   // Analog comparator taps
   output logic comparator_pos_in,
   output logic comparator_neg_in,
   // Port C test pins
   input wire logic [7:4] portcDir,
   input wire logic [7:4] portcOut,
   input wire logic testEnable,
   input wire logic testShift,
   input wire logic testDataOut,
   output logic testDataIn,
   output logic testModeSel,
   output logic testClk,
   // Port B pins
   input wire logic [7:0] portbPinIn,
   output logic [7:0] portbPinOut,
   output logic [7:0] portbPinOe_n,
   output logic [7:0] portbPullup,
   // Port C test pins
   input wire logic [7:4] portcPinIn,
   output logic [7:4] portcPinOut,
   output logic [7:4] portcPinOe_n,
   output logic [7:4] portcPullup
);
   typedef struct packed {
      logic [7:0] pinOut;
      logic [7:0] pinOe_n;
   } state_t;

   state_t state_r;
   state_t state_nxt;

   logic spiMaster;
   logic spiSlave;
   logic [7:0] puOe;
   logic [7:0] puOv;
   logic [7:0] ddOe;
   logic [7:0] ddOv;
   logic [7:0] pvOe;
   logic [7:0] pvOv;
   logic [7:0] cellEn;
   logic [7:0] cellVal;
   logic [7:0] cellPu;
   logic [7:4] tEn;
   logic [7:4] tVal;

   assign spiMaster = serial_periph_enable && serial_master_select;
   assign spiSlave = serial_periph_enable && !serial_master_select;

   // Override table for port B
   always_comb begin
      puOe = 8'h00;
      puOv = 8'h00;
      ddOe = 8'h00;
      ddOv = 8'h00;
      pvOe = 8'h00;
      pvOv = 8'h00;
      // Pull-up value keeps the port bit when a pin is forced in
      puOv[pin_override_pkg::PB_SCK] = portbOut[pin_override_pkg::PB_SCK]
         && !global_pullup_disable;
      puOv[pin_override_pkg::PB_MISO] =
         portbOut[pin_override_pkg::PB_MISO] && !global_pullup_disable;
      puOv[pin_override_pkg::PB_MOSI] =
         portbOut[pin_override_pkg::PB_MOSI] && !global_pullup_disable;
      puOv[pin_override_pkg::PB_SEL] = portbOut[pin_override_pkg::PB_SEL]
         && !global_pullup_disable;
      if (spiSlave) begin
         ddOe[pin_override_pkg::PB_SCK] = 1'b1;
         ddOe[pin_override_pkg::PB_MOSI] = 1'b1;
         ddOe[pin_override_pkg::PB_SEL] = 1'b1;
         puOe[pin_override_pkg::PB_SCK] = 1'b1;
         puOe[pin_override_pkg::PB_MOSI] = 1'b1;
         puOe[pin_override_pkg::PB_SEL] = 1'b1;
         pvOe[pin_override_pkg::PB_MISO] = 1'b1;
         pvOv[pin_override_pkg::PB_MISO] = spiSlaveOut;
      end
      if (spiMaster) begin
         // Select pin left to its direction bit
         ddOe[pin_override_pkg::PB_MISO] = 1'b1;
         puOe[pin_override_pkg::PB_MISO] = 1'b1;
         pvOe[pin_override_pkg::PB_SCK] = 1'b1;
         pvOv[pin_override_pkg::PB_SCK] = spiClkOut;
         pvOe[pin_override_pkg::PB_MOSI] = 1'b1;
         pvOv[pin_override_pkg::PB_MOSI] = spiMasterOut;
      end
      // Timer outputs only replace the value; direction bit gates them
      if (!spiSlave) begin
         pvOe[pin_override_pkg::PB_SEL] = 1'b1;
         pvOv[pin_override_pkg::PB_SEL] = timer3_compare_b_out;
      end
      ddOe[pin_override_pkg::PB_TX1] = serial1_tx_enable;
      ddOv[pin_override_pkg::PB_TX1] = 1'b1;
      pvOe[pin_override_pkg::PB_TX1] = serial1_tx_enable;
      pvOv[pin_override_pkg::PB_TX1] = serial1TxData;
      puOe[pin_override_pkg::PB_TX1] = serial1_tx_enable;
      ddOe[pin_override_pkg::PB_RX1] = serial1_rx_enable;
      puOe[pin_override_pkg::PB_RX1] = serial1_rx_enable;
      puOv[pin_override_pkg::PB_RX1] = portbOut[pin_override_pkg::PB_RX1]
         && !global_pullup_disable;
      pvOe[pin_override_pkg::PB_CMP2] = 1'b1;
      pvOv[pin_override_pkg::PB_CMP2] = timer2_compare_out;
      pvOe[pin_override_pkg::PB_CLK0] = 1'b1;
      pvOv[pin_override_pkg::PB_CLK0] = clock_out_fuse ? clkIoDiv
         : timer0_compare_out;
      ddOe[pin_override_pkg::PB_CLK0] = clock_out_fuse;
      ddOv[pin_override_pkg::PB_CLK0] = 1'b1;
   end

   // Generic cell per port B pin
   genvar gi;
   generate
      for (gi = 0; gi < pin_override_pkg::PORT_W; gi++) begin : g_pb
         pin_cell u_cell (
            .dirBit(portbDir[gi]),
            .outBit(portbOut[gi]),
            .pullupDisable(global_pullup_disable),
            .puOvrEn(puOe[gi]),
            .puOvrVal(puOv[gi]),
            .ddOvrEn(ddOe[gi]),
            .ddOvrVal(ddOv[gi]),
            .pvOvrEn(pvOe[gi]),
            .pvOvrVal(pvOv[gi]),
            .driveEn(cellEn[gi]),
            .driveVal(cellVal[gi]),
            .pullupOn(cellPu[gi])
         );
      end
      for (gi = 4; gi < 8; gi++) begin : g_pc
         test_pin_cell u_tcell (
            .dirBit(portcDir[gi]),
            .outBit(portcOut[gi]),
            .pullupDisable(global_pullup_disable),
            .testEnable(testEnable),
            .isOutput(gi == pin_override_pkg::PC_TDO),
            .shiftActive(testShift),
            .testData(testDataOut),
            .driveEn(tEn[gi]),
            .driveVal(tVal[gi]),
            .pullupOn(portcPullup[gi])
         );
      end
   endgenerate

   // Port B pin drive registered; reset releases all port B pins except the clock output
   always_comb begin
      state_nxt.pinOut = cellVal;
      state_nxt.pinOe_n = ~cellEn;
      if (!reset_n) begin
         state_nxt.pinOut = pin_override_pkg::RESET_OUT;
         state_nxt.pinOe_n = pin_override_pkg::RESET_OE_N;
         if (clock_out_fuse) begin
            state_nxt.pinOut[pin_override_pkg::PB_CLK0] = clkIoDiv;
            state_nxt.pinOe_n[pin_override_pkg::PB_CLK0] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      state_r <= state_nxt;
   end

   assign portbPinOut = state_r.pinOut;
   assign portbPinOe_n = state_r.pinOe_n;
   // Pull-ups stay combinational so test pins keep theirs through reset
   assign portbPullup = reset_n ? cellPu : 8'h00;
   assign portcPinOut = tVal;
   assign portcPinOe_n = ~tEn;

   // Peripheral inputs from pins
   assign spiClkIn = portbPinIn[pin_override_pkg::PB_SCK];
   assign spiMasterIn = portbPinIn[pin_override_pkg::PB_MISO];
   assign spiSlaveIn = portbPinIn[pin_override_pkg::PB_MOSI];
   assign spiSlaveActive = spiSlave
      && !portbPinIn[pin_override_pkg::PB_SEL];
   assign serial1RxData = portbPinIn[pin_override_pkg::PB_RX1];
   assign comparator_pos_in = portbPinIn[pin_override_pkg::PB_RX1];
   assign comparator_neg_in = portbPinIn[pin_override_pkg::PB_TX1];
   assign timer0_ext_count_in = portbPinIn[pin_override_pkg::PB_CLK0];
   assign timer1_ext_count_in = portbPinIn[pin_override_pkg::PB_CMP2];
   assign testDataIn = portcPinIn[pin_override_pkg::PC_TDI];
   assign testModeSel = portcPinIn[pin_override_pkg::PC_TMS];
   assign testClk = portcPinIn[pin_override_pkg::PC_TCK];

   // Checks
   property p_master_in;
      @(posedge clk_sys) disable iff (!reset_n)
      spiMaster ##1 reset_n |-> portbPinOe_n[pin_override_pkg::PB_MISO];
   endproperty
   a_master_in: assert property (p_master_in)
      else $error("data-in pin driven in master mode");
   property p_slave_mosi;
      @(posedge clk_sys) disable iff (!reset_n)
      spiSlave ##1 reset_n |-> portbPinOe_n[pin_override_pkg::PB_MOSI];
   endproperty
   a_slave_mosi: assert property (p_slave_mosi)
      else $error("data-out pin driven in slave mode");
   property p_slave_sck;
      @(posedge clk_sys) disable iff (!reset_n)
      spiSlave ##1 reset_n |-> portbPinOe_n[pin_override_pkg::PB_SCK];
   endproperty
   a_slave_sck: assert property (p_slave_sck)
      else $error("clock pin driven in slave mode");
   property p_slave_sel;
      @(posedge clk_sys) disable iff (!reset_n)
      spiSlave ##1 reset_n |-> portbPinOe_n[pin_override_pkg::PB_SEL];
   endproperty
   a_slave_sel: assert property (p_slave_sel)
      else $error("select pin driven in slave mode");
   property p_tx;
      @(posedge clk_sys) disable iff (!reset_n)
      serial1_tx_enable ##1 reset_n |-> !portbPinOe_n[pin_override_pkg::PB_TX1]
         && portbPinOut[pin_override_pkg::PB_TX1] == $past(serial1TxData);
   endproperty
   a_tx: assert property (p_tx)
      else $error("transmit pin not driving data");
   property p_timer2;
      @(posedge clk_sys) disable iff (!reset_n)
      portbDir[pin_override_pkg::PB_CMP2] ##1 reset_n |->
         portbPinOut[pin_override_pkg::PB_CMP2] == $past(timer2_compare_out);
   endproperty
   a_timer2: assert property (p_timer2)
      else $error("timer2 output missing");
   property p_clkout;
      @(posedge clk_sys) clock_out_fuse |=>
         !portbPinOe_n[pin_override_pkg::PB_CLK0]
         && portbPinOut[pin_override_pkg::PB_CLK0] == $past(clkIoDiv);
   endproperty
   a_clkout: assert property (p_clkout)
      else $error("clock output not driven");
   property p_tdo;
      @(posedge clk_sys) disable iff (!reset_n)
      testEnable && !testShift |-> portcPinOe_n[pin_override_pkg::PC_TDO];
   endproperty
   a_tdo: assert property (p_tdo)
      else $error("test output driven outside shift");
   property p_slave_miso;
      @(posedge clk_sys) disable iff (!reset_n)
      spiSlave ##1 reset_n |->
         portbPinOe_n[pin_override_pkg::PB_MISO] ==
         !$past(portbDir[pin_override_pkg::PB_MISO]);
   endproperty
   a_slave_miso: assert property (p_slave_miso)
      else $error("data-in pin ignores direction bit in slave mode");
   property p_master_sel;
      @(posedge clk_sys) disable iff (!reset_n)
      spiMaster ##1 reset_n |->
         portbPinOe_n[pin_override_pkg::PB_SEL] ==
         !$past(portbDir[pin_override_pkg::PB_SEL]);
   endproperty
   a_master_sel: assert property (p_master_sel)
      else $error("select pin ignores direction bit in master mode");
   property p_forced_pu;
      @(posedge clk_sys) disable iff (!reset_n)
      spiSlave |-> portbPullup[pin_override_pkg::PB_MOSI] ==
         (portbOut[pin_override_pkg::PB_MOSI] && !global_pullup_disable);
   endproperty
   a_forced_pu: assert property (p_forced_pu)
      else $error("forced input lost its pull-up control");
   property p_timer3;
      @(posedge clk_sys) disable iff (!reset_n)
      !spiSlave && portbDir[pin_override_pkg::PB_SEL] ##1 reset_n |->
         !portbPinOe_n[pin_override_pkg::PB_SEL]
         && portbPinOut[pin_override_pkg::PB_SEL] ==
         $past(timer3_compare_b_out);
   endproperty
   a_timer3: assert property (p_timer3)
      else $error("timer3 output missing");
   property p_rx;
      @(posedge clk_sys) disable iff (!reset_n)
      serial1_rx_enable ##1 reset_n |->
         portbPinOe_n[pin_override_pkg::PB_RX1];
   endproperty
   a_rx: assert property (p_rx)
      else $error("receive pin driven while receiver enabled");
   property p_timer0;
      @(posedge clk_sys) disable iff (!reset_n)
      !clock_out_fuse && portbDir[pin_override_pkg::PB_CLK0] ##1 reset_n
         |-> !portbPinOe_n[pin_override_pkg::PB_CLK0]
         && portbPinOut[pin_override_pkg::PB_CLK0] ==
         $past(timer0_compare_out);
   endproperty
   a_timer0: assert property (p_timer0)
      else $error("timer0 output missing");
   // No disable here: the clock must keep running through reset
   property p_clk_reset;
      @(posedge clk_sys) !reset_n && clock_out_fuse |=>
         !portbPinOe_n[pin_override_pkg::PB_CLK0];
   endproperty
   a_clk_reset: assert property (p_clk_reset)
      else $error("clock output released during reset");
   property p_test_pu;
      @(posedge clk_sys) testEnable |->
         portcPullup[pin_override_pkg::PC_TDI]
         && portcPullup[pin_override_pkg::PC_TMS]
         && portcPullup[pin_override_pkg::PC_TCK];
   endproperty
   a_test_pu: assert property (p_test_pu)
      else $error("test pin pull-up dropped");
   property p_test_port;
      @(posedge clk_sys) testEnable |->
         portcPinOe_n[pin_override_pkg::PC_TDI];
   endproperty
   a_test_port: assert property (p_test_port)
      else $error("test data input pin driven by the port");
   c_master: cover property (@(posedge clk_sys) spiMaster);
   c_slave: cover property (@(posedge clk_sys) spiSlaveActive);
   c_clk: cover property (@(posedge clk_sys) !reset_n && clock_out_fuse);
   c_test: cover property (@(posedge clk_sys) testEnable && testShift);
endmodule

// ---- inc/pin_override_pkg.sv ----
// Shared constants for the port B / port C override block
package pin_override_pkg;
   localparam int PORT_W = 8;
   // Port B pin positions
   localparam int PB_CLK0 = 0;
   localparam int PB_CMP2 = 1;
   localparam int PB_RX1 = 2;
   localparam int PB_TX1 = 3;
   localparam int PB_SEL = 4;
   localparam int PB_MOSI = 5;
   localparam int PB_MISO = 6;
   localparam int PB_SCK = 7;
   // Port C test pin positions
   localparam int PC_TCK = 4;
   localparam int PC_TMS = 5;
   localparam int PC_TDO = 6;
   localparam int PC_TDI = 7;
   // Value after reset of the registered pin drive
   localparam logic [7:0] RESET_OUT = 8'h00;
   localparam logic [7:0] RESET_OE_N = 8'hFF;
endpackage

// ---- rtl/pin_cell.sv ----
// One generic override cell: port value versus alternate override
`timescale 1ns/1ns
module pin_cell (
   // Port register side
   input wire logic dirBit,
   input wire logic outBit,
   input wire logic pullupDisable,
   // Override enables and values
   input wire logic puOvrEn,
   input wire logic puOvrVal,
   input wire logic ddOvrEn,
   input wire logic ddOvrVal,
   input wire logic pvOvrEn,
   input wire logic pvOvrVal,
   // Resolved pin controls
   output logic driveEn,
   output logic driveVal,
   output logic pullupOn
);
   logic dirEff;
   always_comb begin
      dirEff = ddOvrEn ? ddOvrVal : dirBit;
      driveEn = dirEff;
      driveVal = pvOvrEn ? pvOvrVal : outBit;
      if (puOvrEn) begin
         pullupOn = puOvrVal;
      end else begin
         pullupOn = !dirEff && outBit && !pullupDisable;
      end
   end
endmodule

// ---- rtl/test_pin_cell.sv ----
// Port C test-interface pin: takes pins away from the port when enabled
`timescale 1ns/1ns
module test_pin_cell (
   // Port side
   input wire logic dirBit,
   input wire logic outBit,
   input wire logic pullupDisable,
   // Test interface side
   input wire logic testEnable,
   input wire logic isOutput,
   input wire logic shiftActive,
   input wire logic testData,
   // Resolved controls
   output logic driveEn,
   output logic driveVal,
   output logic pullupOn
);
   always_comb begin
      if (testEnable) begin
         driveEn = isOutput && shiftActive;
         driveVal = testData;
         pullupOn = 1'b1;
      end else begin
         driveEn = dirBit;
         driveVal = outBit;
         pullupOn = !dirBit && outBit && !pullupDisable;
      end
   end
endmodule

// ---- tb/periph_model.sv ----
// Behavioural stand-in for the peripherals feeding the override block
`timescale 1ns/1ns
module periph_model (
   // Clock
   input wire logic clk_sys,
   // Peripheral drive values
   output logic spiClkOut,
   output logic spiMasterOut,
   output logic spiSlaveOut,
   output logic serial1TxData,
   output logic timer0_compare_out,
   output logic timer2_compare_out,
   output logic timer3_compare_b_out,
   output logic clkIoDiv,
   output logic testDataOut
);
   logic [7:0] cnt_r = 8'h00;
   // Moves on the falling edge so the block always samples settled values
   always @(negedge clk_sys) begin
      cnt_r <= cnt_r + 8'h01;
   end
   // Divided clock stays slower than the system clock
   assign clkIoDiv = cnt_r[1];
   assign spiClkOut = cnt_r[1] ^ cnt_r[0];
   assign spiMasterOut = cnt_r[2];
   assign spiSlaveOut = cnt_r[3];
   assign serial1TxData = ~cnt_r[1];
   assign timer0_compare_out = cnt_r[0];
   assign timer2_compare_out = cnt_r[2];
   assign timer3_compare_b_out = ~cnt_r[0];
   assign testDataOut = cnt_r[0] ^ cnt_r[2];
endmodule

// ---- tb/test_port_b_c_alt_function_override.sv ----
// Self-checking bench for the port B / port C override block
`timescale 1ns/1ns
module test_port_b_c_alt_function_override;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] portbDir = 8'h00, portbOut = 8'h00, extB = 8'hA5;
   logic [7:4] portcDir = 4'h0, portcOut = 4'h0, extC = 4'h9;
   logic global_pullup_disable = 1'b0, serial_periph_enable = 1'b0;
   logic serial_master_select = 1'b0, serial1_tx_enable = 1'b0;
   logic serial1_rx_enable = 1'b0, clock_out_fuse = 1'b1;
   logic testEnable = 1'b1, testShift = 1'b0;
   wire spiClkOut, spiMasterOut, spiSlaveOut, serial1TxData, clkIoDiv;
   wire timer0_compare_out, timer2_compare_out, timer3_compare_b_out;
   wire testDataOut, spiClkIn, spiMasterIn, spiSlaveIn, spiSlaveActive;
   wire serial1RxData, timer0_ext_count_in, timer1_ext_count_in;
   wire comparator_pos_in, comparator_neg_in, testDataIn, testModeSel;
   wire testClk;
   wire [7:0] portbPinIn, portbPinOut, portbPinOe_n, portbPullup;
   wire [7:4] portcPinIn, portcPinOut, portcPinOe_n, portcPullup;
   int n_fail = 0;
   int checks = 0;
   logic [7:0] expOe, expVal, expPu, fPu, regOe, regVal;
   logic [7:4] cOe, cVal, cPu;

   port_b_c_alt_function_override u_port_b_c_alt_function_override (.*);
   periph_model u_periph_model (.*);

   // Pin level: driven value where enabled, outside world elsewhere
   assign portbPinIn = (portbPinOut & ~portbPinOe_n) | (extB & portbPinOe_n);
   assign portcPinIn = (portcPinOut & ~portcPinOe_n) | (extC & portcPinOe_n);

   always #25 clk_sys = ~clk_sys;

   always @* begin
      fPu = portbOut & {8{~global_pullup_disable}};
      expOe = ~portbDir;
      expVal = portbOut;
      expPu = ~portbDir & fPu;
      expVal[0] = clock_out_fuse ? clkIoDiv : timer0_compare_out;
      expVal[1] = timer2_compare_out;
      expVal[4] = timer3_compare_b_out;
      if (clock_out_fuse) expOe[0] = 1'b0;
      // A pin forced to drive the clock has no pull-up
      if (clock_out_fuse) expPu[0] = 1'b0;
      if (serial_periph_enable & serial_master_select) begin
         expOe[6] = 1'b1;
         expPu[6] = fPu[6];
         expVal[7] = spiClkOut;
         expVal[5] = spiMasterOut;
      end
      if (serial_periph_enable & ~serial_master_select) begin
         expOe[7] = 1'b1;
         expOe[5] = 1'b1;
         expOe[4] = 1'b1;
         expPu[7] = fPu[7];
         expPu[5] = fPu[5];
         expPu[4] = fPu[4];
         expVal[6] = spiSlaveOut;
      end
      if (serial1_tx_enable) begin
         expOe[3] = 1'b0;
         expVal[3] = serial1TxData;
         expPu[3] = 1'b0;
      end
      if (serial1_rx_enable) begin
         expOe[2] = 1'b1;
         expPu[2] = fPu[2];
      end
      if (!reset_n) begin
         expOe = {7'h7F, ~clock_out_fuse};
         expPu = 8'h00;
      end
      cOe = testEnable ? {1'b1, ~testShift, 2'b11} : ~portcDir;
      cVal = testEnable ? {1'b0, testDataOut, 2'b00} : portcOut;
      cPu = ~portcDir & portcOut & {4{~global_pullup_disable}};
      if (testEnable) cPu = 4'hF;
   end

   // Registered pin drive lags its inputs by one edge
   always @(posedge clk_sys) begin
      regOe <= expOe;
      regVal <= expVal;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_all;
      @(posedge clk_sys);
      @(negedge clk_sys);
      #5;
      check(portbPinOe_n, regOe);
      check(portbPinOut & ~regOe, regVal & ~regOe);
      check(portbPullup, expPu);
      check({spiClkIn, spiMasterIn, spiSlaveIn, serial1RxData,
         comparator_neg_in, timer1_ext_count_in, timer0_ext_count_in,
         comparator_pos_in}, {portbPinIn[7:5], portbPinIn[2],
         portbPinIn[3], portbPinIn[1:0], portbPinIn[2]});
      check({7'h00, spiSlaveActive}, {7'h00, serial_periph_enable &
         ~serial_master_select & ~portbPinIn[4]});
      check({portcPinOe_n, portcPullup}, {cOe, cPu});
      check({4'h0, portcPinOut & ~cOe}, {4'h0, cVal & ~cOe});
      check({5'h00, testDataIn, testModeSel, testClk},
         {5'h00, portcPinIn[7], portcPinIn[5], portcPinIn[4]});
   endtask

   task automatic t_spi;
      serial_periph_enable = 1'b1;
      portbDir = 8'hFF;
      portbOut = 8'hF0;
      extB = 8'h00;
      cmp_all();
      extB = 8'h10;
      cmp_all();
      serial_master_select = 1'b1;
      cmp_all();
      portbDir = 8'h00;
      cmp_all();
      serial_periph_enable = 1'b0;
      $display("spi test done");
   endtask

   task automatic t_serial1;
      serial1_tx_enable = 1'b1;
      serial1_rx_enable = 1'b1;
      portbDir = 8'h04;
      portbOut = 8'h0C;
      cmp_all();
      global_pullup_disable = 1'b1;
      cmp_all();
      global_pullup_disable = 1'b0;
      serial1_tx_enable = 1'b0;
      serial1_rx_enable = 1'b0;
      portbOut = 8'h00;
      cmp_all();
      $display("serial1 test done");
   endtask

   task automatic t_timer;
      clock_out_fuse = 1'b0;
      portbDir = 8'h13;
      repeat (4) cmp_all();
      portbDir = 8'h00;
      cmp_all();
      clock_out_fuse = 1'b1;
      repeat (4) cmp_all();
      $display("timer test done");
   endtask

   task automatic t_test;
      testEnable = 1'b1;
      portcDir = 4'hF;
      portcOut = 4'hA;
      cmp_all();
      testShift = 1'b1;
      repeat (2) cmp_all();
      testEnable = 1'b0;
      cmp_all();
      $display("test port done");
   endtask

   task automatic end_sim;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (2) cmp_all();
      $display("reset test done");
      repeat (4) @(negedge clk_sys);
      reset_n = 1'b1;
      t_spi();
      t_serial1();
      t_timer();
      t_test();
      end_sim();
   end

   initial begin
      #20000;
      n_fail++;
      end_sim();
   end
endmodule
